/* rtl/icva_consts.vh */
`ifndef ICVA_CONSTS_VH
`define ICVA_CONSTS_VH
// Configuration bit addresses (bit-addressed register space)
`define ICVA_SWRST_BIT 12'd2922
`define ICVA_LOCK_BIT 12'd2924
`define ICVA_VIN_LO 12'd2840
`define ICVA_VIN_HI 12'd2851
`define ICVA_NODE_LO 12'd2872
`define ICVA_NODE_HI 12'd2887
`define ICVA_ADDR_W 12
`define ICVA_VIN_W 12
`define ICVA_NODE_W 16
`define ICVA_SHARED_W 4
`define ICVA_STAGES 5
`define ICVA_VIN_RESET 12'h000
// Reload sequence length in core_clk cycles
`define ICVA_POR_CYCLES 8'd32
`endif

/* rtl/icva_delay_chain.v */
`timescale 1ns/1ps
`default_nettype none
// Widths in the port list need the constants first
`include "icva_consts.vh"
module icva_delay_chain (
   input wire core_clk,
   input wire sys_rst,
   input wire din,
   input wire pipe_rst,
   input wire rst_pol_high,
   output wire [`ICVA_STAGES-1:0] stage_d
);
   reg [`ICVA_STAGES-1:0] delay_chain_stages;
   wire clr;
   assign clr = rst_pol_high ? pipe_rst : ~pipe_rst;
   assign stage_d = {delay_chain_stages[`ICVA_STAGES-2:0], din};
   always @(posedge core_clk) begin
      if (sys_rst || clr) begin
         delay_chain_stages <= {`ICVA_STAGES{1'b0}};
      end else begin
         delay_chain_stages <= stage_d;
      end
   end
endmodule
`default_nettype wire

/* rtl/icva_top.v */
// Functional notes
// - The I2C target lets a master read and write configuration bits.
// - Writing one to bit 2922 restarts the power-on reset sequence.
// - The software reset reloads the virtual input bits and the lock bit from NVM.
// - Outputs stay high-impedance while the reset sequence runs.
// - Bit 2922 clears itself to zero when the reset sequence ends.
// - Bits 2851..2840 drive matrix inputs 75..64 as virtual inputs.
// - Bits 2887..2872 read back live internal node values.
// - With bit 2924 set, readout of virtual input bits 2851..2840 is blocked.
// - Virtual outputs and pipe delay share one 8-bit matrix output group.
// - Each of four shared lines selects virtual bit or pipe output.
// - The pipe reset polarity is configurable.
// - The pipe output selects any of the five stage data inputs.
`timescale 1ns/1ps
`default_nettype none
// Widths in the port list need the constants first
`include "icva_consts.vh"
module icva_top (
   input wire core_clk,
   input wire sys_rst,
   input wire wr_en,
   input wire rd_en,
   input wire [`ICVA_ADDR_W-1:0] bit_addr,
   input wire wr_bit,
   output reg rd_bit,
   output reg rd_valid,
   input wire [`ICVA_VIN_W-1:0] nvm_vin,
   input wire nvm_lock,
   input wire [`ICVA_NODE_W-1:0] node_state,
   input wire [`ICVA_SHARED_W-1:0] vout_bits,
   input wire [`ICVA_SHARED_W-1:0] shared_sel_pipe,
   input wire [2:0] pipe_tap_sel,
   input wire pipe_din,
   input wire pipe_rst,
   input wire pipe_rst_pol_high,
   output reg [`ICVA_VIN_W-1:0] matrix_vin,
   output reg [7:0] shared_out,
   output reg outputs_tristate,
   output reg swrst_flag,
   output reg lock_flag
);
   localparam ST_RUN = 2'b01;
   localparam ST_POR = 2'b10;
   reg [1:0] state;
   reg [7:0] por_cnt;
   reg [`ICVA_VIN_W-1:0] vin;
   wire [`ICVA_STAGES-1:0] stage_d;
   wire pipe_out;
   wire in_vin;
   wire in_node;
   wire [`ICVA_ADDR_W-1:0] vin_idx;
   wire [`ICVA_ADDR_W-1:0] node_idx;
   wire [`ICVA_SHARED_W-1:0] shared_mux;
   assign in_vin = bit_addr >= `ICVA_VIN_LO && bit_addr <= `ICVA_VIN_HI;
   assign in_node = bit_addr >= `ICVA_NODE_LO && bit_addr <= `ICVA_NODE_HI;
   assign vin_idx = bit_addr - `ICVA_VIN_LO;
   assign node_idx = bit_addr - `ICVA_NODE_LO;
   // tap selection, out of range taps the input
   assign pipe_out = (pipe_tap_sel < 3'd5) ? stage_d[pipe_tap_sel] : pipe_din;
   icva_delay_chain u_chain (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .din(pipe_din),
      .pipe_rst(pipe_rst),
      .rst_pol_high(pipe_rst_pol_high),
      .stage_d(stage_d)
   );
   genvar g;
   generate
      for (g = 0; g < `ICVA_SHARED_W; g = g + 1) begin : g_share
         assign shared_mux[g] = shared_sel_pipe[g] ? pipe_out : vout_bits[g];
      end
   endgenerate
   always @(posedge core_clk) begin
      if (sys_rst) begin
         state <= ST_POR;
         por_cnt <= 8'h00;
         vin <= `ICVA_VIN_RESET;
         swrst_flag <= 1'b0;
         lock_flag <= 1'b0;
         outputs_tristate <= 1'b1;
         rd_bit <= 1'b0;
         rd_valid <= 1'b0;
         matrix_vin <= `ICVA_VIN_RESET;
         shared_out <= 8'h00;
      end else begin
         rd_valid <= 1'b0;
         rd_bit <= 1'b0;
         case (state)
            ST_POR: begin
               outputs_tristate <= 1'b1;
               vin <= nvm_vin;
               lock_flag <= nvm_lock;
               if (por_cnt == `ICVA_POR_CYCLES - 8'h01) begin
                  state <= ST_RUN;
                  swrst_flag <= 1'b0;
                  outputs_tristate <= 1'b0;
               end else begin
                  por_cnt <= por_cnt + 8'h01;
               end
            end
            ST_RUN: begin
               if (wr_en) begin
                  if (bit_addr == `ICVA_SWRST_BIT && wr_bit) begin
                     swrst_flag <= 1'b1;
                     state <= ST_POR;
                     por_cnt <= 8'h00;
                     outputs_tristate <= 1'b1;
                  end else if (bit_addr == `ICVA_LOCK_BIT && wr_bit) begin
                     lock_flag <= 1'b1;
                  end else if (in_vin) begin
                     vin[vin_idx[3:0]] <= wr_bit;
                  end
               end else if (rd_en) begin
                  rd_valid <= 1'b1;
                  if (in_node) begin
                     rd_bit <= node_state[node_idx[3:0]];
                  end else if (bit_addr == `ICVA_SWRST_BIT) begin
                     rd_bit <= swrst_flag;
                  end else if (bit_addr == `ICVA_LOCK_BIT) begin
                     rd_bit <= lock_flag;
                  end else if (in_vin && !lock_flag) begin
                     rd_bit <= vin[vin_idx[3:0]];
                  end
               end
            end
            default: begin
               state <= ST_POR;
               por_cnt <= 8'h00;
            end
         endcase
         matrix_vin <= vin;
         // shared 8-bit group, upper half virtual
         shared_out <= {vout_bits, shared_mux};
      end
   end
endmodule
`default_nettype wire

/* testbench/icva_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module icva_master_model (
   input wire logic core_clk,
   input wire logic rd_bit,
   output var logic wr_en = 1'b0,
   output var logic rd_en = 1'b0,
   output var logic wr_bit = 1'b0,
   output var logic [11:0] bit_addr = 12'h000
);
task acc(input logic w, input logic [11:0] a, input logic b,
   output logic q);
   @(posedge core_clk);
   #1 {wr_en, rd_en, bit_addr, wr_bit} = {w, !w, a, b};
   @(posedge core_clk);
   #1 {wr_en, rd_en, bit_addr, wr_bit} = {2'b00, ~a, !b};
   q = rd_bit;
endtask
endmodule
`default_nettype wire

/* testbench/icva_props.sv */
`timescale 1ns/1ps
`default_nettype none
module icva_props (
   input wire logic core_clk, sys_rst, wr_en, rd_en, wr_bit, rd_bit,
   input wire logic rd_valid, outputs_tristate, swrst_flag, lock_flag,
   input wire logic [11:0] bit_addr, matrix_vin,
   input wire logic [15:0] node_state,
   input wire logic [3:0] vout_bits, shared_sel_pipe,
   input wire logic [7:0] shared_out
);
wire live = !outputs_tristate;
wire rq = rd_en && !wr_en && live;
wire vin = bit_addr >= 12'd2840 && bit_addr <= 12'd2851;
wire node = bit_addr >= 12'd2872 && bit_addr <= 12'd2887;
default clocking @(posedge core_clk); endclocking
default disable iff (sys_rst);
rd_reply_a: assert property (rq |=> rd_valid)
   else $error("no reply");
sw_start_a: assert property (wr_en && live && wr_bit &&
   bit_addr == 12'd2922 |=> swrst_flag && outputs_tristate)
   else $error("no restart");
sw_float_a: assert property (swrst_flag |-> outputs_tristate)
   else $error("driven in reset");
sw_clear_a: assert property ($rose(swrst_flag) |->
   ##[8:40] !swrst_flag) else $error("flag stuck");
vin_set_a: assert property (wr_en && live && vin |-> ##2
   matrix_vin[$past(bit_addr, 2) - 12'd2840] == $past(wr_bit, 2))
   else $error("bad vin");
node_rd_a: assert property (rq && node |=>
   rd_bit == $past(node_state[bit_addr - 12'd2872])) else $error("bad node");
lock_rd_a: assert property (rq && lock_flag && vin |=> !rd_bit)
   else $error("leak");
line_sel_a: assert property (live && $past(live) |->
   ((shared_out ^ {2{$past(vout_bits)}}) &
   {4'hF, ~$past(shared_sel_pipe)}) == 8'h00) else $error("bad line");
endmodule
bind icva_top icva_props icva_props_i (.core_clk, .sys_rst, .wr_en, .rd_en,
   .wr_bit, .rd_bit, .rd_valid, .outputs_tristate, .swrst_flag, .lock_flag,
   .bit_addr, .matrix_vin, .node_state, .vout_bits, .shared_sel_pipe,
   .shared_out);
`default_nettype wire

/* testbench/icva_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module icva_top_tb;
logic core_clk = 0, sys_rst = 1, nvm_lock = 0, pipe_din = 0;
logic pipe_rst = 0, pol = 0, q, b;
logic [11:0] nvm_vin = 12'h000, ev;
logic [15:0] node = 16'h0000;
logic [3:0] vout = 4'h0, sel = 4'h0;
logic [2:0] tap = 3'h0;
wire wr_en, rd_en, wr_bit, rd_bit, otri, swf, lkf;
wire [11:0] bit_addr, vin;
wire [7:0] sh;
integer seed = 97, bad_count = 0, comparisons = 0, cyc = 0, i, k;
always #25 core_clk = ~core_clk;
icva_top icva_top_i (.core_clk, .sys_rst, .wr_en, .rd_en, .bit_addr,
   .wr_bit, .rd_bit, .rd_valid(), .nvm_vin, .nvm_lock, .node_state(node),
   .vout_bits(vout), .shared_sel_pipe(sel), .pipe_tap_sel(tap), .pipe_din,
   .pipe_rst, .pipe_rst_pol_high(pol), .matrix_vin(vin), .shared_out(sh),
   .outputs_tristate(otri), .swrst_flag(swf), .lock_flag(lkf));
icva_master_model icva_master_model_i (.core_clk, .rd_bit, .wr_en, .rd_en,
   .wr_bit, .bit_addr);
task chk(input logic [15:0] s, input logic [15:0] e);
   comparisons = comparisons + 1;
   if (s !== e) begin
      bad_count = bad_count + 1;
      $display("mismatch at %0t: %h not %h", $time, s, e);
   end
endtask
task test_done;
   $display("comparisons %0d bad_count %0d", comparisons, bad_count);
   if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
   else $display("TESTS FAILED");
   $finish;
endtask
task acc(input logic w, input logic [11:0] a, input logic d);
   icva_master_model_i.acc(w, a, d, q);
endtask
task wait_run;
   repeat (40) if (otri !== 1'b0) @(posedge core_clk);
   #1 chk(otri, 1'b0);
endtask
always @(posedge core_clk) begin
   cyc <= cyc + 1;
   if (cyc == 2000) begin
      bad_count = bad_count + 1;
      test_done;
   end
end
initial begin
   nvm_vin = $random(seed);
   repeat (2) @(posedge core_clk);
   #1 sys_rst = 0;
   wait_run;
   chk(vin, nvm_vin);
   ev = nvm_vin;
   for (i = 0; i < 16; i = i + 1) begin
      k = {$random(seed)} % 12;
      {b, vout, sel, tap, node} = $random(seed);
      acc(1'b1, 12'(2840 + k), b);
      ev[k] = b;
   end
   repeat (2) @(posedge core_clk);
   #1 chk(vin, ev);
   for (i = 0; i < 16; i = i + 1) begin
      acc(1'b0, 12'(2872 + i), 1'b0);
      chk(q, node[i]);
   end
   acc(1'b0, 12'hFFF, 1'b0);
   chk(q, 1'b0);
   $display("access done");
   {nvm_lock, nvm_vin} = 13'h1FFF;
   acc(1'b1, 12'd2922, 1'b1);
   chk({swf, otri}, 2'b11);
   wait_run;
   chk({swf, lkf, vin}, {2'b01, nvm_vin});
   acc(1'b0, 12'd2841, 1'b0);
   chk(q, 1'b0);
   $display("reset done");
   {sel, tap, pipe_din} = 8'hF9;
   for (i = 0; i < 2; i = i + 1) begin
      {pol, pipe_rst} = {2{i[0]}};
      repeat (8) @(posedge core_clk);
      #1 chk(sh[3:0], 4'h0);
      pipe_rst = !pol;
      repeat (8) @(posedge core_clk);
      #1 chk(sh[3:0], 4'hF);
   end
   $display("pipe done");
   test_done;
end
endmodule
`default_nettype wire
